// ==== hw/mfdg_consts.vh ====
// Constants for the MAC frame/duplex/gap configuration slice
// Assumes a 32-bit classic Wishbone slave, one 125 MHz clock
`ifndef MFDG_CONSTS_VH
`define MFDG_CONSTS_VH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define MFDG_ADDR_CTRL2     8'h00
`define MFDG_ADDR_GAP       8'h04
`define MFDG_ADDR_MAXLEN    8'h08
`define MFDG_ADDR_STATUS    8'h0C

// ****************************************
// Field positions and reset values
// ****************************************
`define MFDG_BIT_DUPLEX     0
`define MFDG_BIT_RSVD1      1
`define MFDG_BIT_OVERSIZE   2
`define MFDG_BIT_HDR        3
`define MFDG_BIT_CRC        4
`define MFDG_CTRL2_RST      16'h40B2
`define MFDG_CTRL2_WMASK    16'h70FF
`define MFDG_GAP_RST        7'h12
`define MFDG_MAXLEN_RST     16'h05EE
`define MFDG_FD_OFFSET      8'h03
`define MFDG_HD_OFFSET      8'h06

`endif

// ==== hw/mfdg_cfg.v ====
// MAC configuration slice: control register two, back-to-back gap,
// maximum frame length, frame-length policing and gap timing.
// Assumes a classic Wishbone master and a MAC datapath that marks
// frame boundaries with txFrame/rxFrame and byte strobes.
//
// The register addresses and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "mfdg_consts.vh"
module mfdg_cfg (
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        txFrame,
    input  wire        txByte,
    input  wire        rxFrame,
    input  wire        rxByte,
    input  wire        nibbleTick,
    output reg         fullDuplex_q,
    output reg         crcAppend_q,
    output reg         txAbort_q,
    output reg         rxAbort_q,
    output reg         gapDone_q
);
    reg  [15:0] ctrl2_q;
    reg  [6:0]  gap_q;
    reg  [15:0] maxLen_q;
    reg         oversize_q;
    reg  [1:0]  gapState_q;
    reg  [1:0]  gapState_d;
    reg  [7:0]  gapCnt_d;
    reg         gapDone_d;
    reg         txPrev_q;
    reg  [7:0]  gapCnt_q;
    reg  [15:0] wdat;
    wire        req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        wr      = req & wb_we_i;
    wire        idle    = ~txFrame & ~rxFrame;
    wire        txEnd   = txPrev_q & ~txFrame;
    wire [7:0]  gapFull = {1'b0, gap_q} + (fullDuplex_q ? `MFDG_FD_OFFSET : `MFDG_HD_OFFSET);
    wire [1:0]  frameIn = {rxFrame, txFrame};
    wire [1:0]  byteIn  = {rxByte, txByte};
    wire [1:0]  overLimit;
    wire        hitCtrl2;
    wire        hitGap;
    wire        hitMaxLen;
    genvar      dirIdx;

    // Gap timer states, one-hot
    localparam [1:0] GAP_IDLE  = 2'b01;
    localparam [1:0] GAP_COUNT = 2'b10;

    // Merge byte lanes 0 and 1 with old contents
    function [15:0] laneMerge;
        input [15:0] old;
        input [15:0] nw;
        input [1:0]  sel;
        begin
            laneMerge = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
        end
    endfunction

    // Address match, shared by every register write decode
    function regHit;
        input [7:0] adr;
        input [7:0] target;
        begin
            regHit = (adr == target);
        end
    endfunction

    // Saturating byte count, cleared between frames
    function [15:0] lenNext;
        input [15:0] cnt;
        input        inFrame;
        input        byteStrobe;
        begin
            if (!inFrame) begin
                lenNext = 16'h0000;
            end else if (byteStrobe && cnt != 16'hFFFF) begin
                lenNext = cnt + 16'h0001;
            end else begin
                lenNext = cnt;
            end
        end
    endfunction

    assign hitCtrl2  = wr & regHit(wb_adr_i, `MFDG_ADDR_CTRL2);
    assign hitGap    = wr & regHit(wb_adr_i, `MFDG_ADDR_GAP);
    assign hitMaxLen = wr & regHit(wb_adr_i, `MFDG_ADDR_MAXLEN);

    always @* begin
        wdat = wb_dat_i[15:0];
    end

    // ****************************************
    // Register bus
    // ****************************************
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl2_q  <= `MFDG_CTRL2_RST;
            gap_q    <= `MFDG_GAP_RST;
            maxLen_q <= `MFDG_MAXLEN_RST;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= 32'h0000_0000;
            if (hitCtrl2) begin
                ctrl2_q <= laneMerge(ctrl2_q, wdat, wb_sel_i[1:0]) & `MFDG_CTRL2_WMASK;
            end
            if (hitGap && wb_sel_i[0]) begin
                gap_q <= wdat[6:0];
            end
            if (hitMaxLen) begin
                maxLen_q <= laneMerge(maxLen_q, wdat, wb_sel_i[1:0]);
            end
            if (req && !wb_we_i) begin
                case (wb_adr_i)
                    `MFDG_ADDR_CTRL2:  wb_dat_o <= {16'h0000, ctrl2_q};
                    `MFDG_ADDR_GAP:    wb_dat_o <= {25'h000_0000, gap_q};
                    `MFDG_ADDR_MAXLEN: wb_dat_o <= {16'h0000, maxLen_q};
                    `MFDG_ADDR_STATUS: wb_dat_o <= {27'h000_0000, gapDone_q, rxAbort_q, txAbort_q,
                                                    crcAppend_q, fullDuplex_q};
                    default:           wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ****************************************
    // Config sampling and length policing
    // ****************************************
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            fullDuplex_q <= 1'b0;
            crcAppend_q  <= 1'b1;
            oversize_q   <= 1'b0;
            txAbort_q    <= 1'b0;
            rxAbort_q    <= 1'b0;
            txPrev_q     <= 1'b0;
        end else begin
            txPrev_q <= txFrame;
            // Latch only when no frame runs
            if (idle) begin
                fullDuplex_q <= ctrl2_q[`MFDG_BIT_DUPLEX];
                crcAppend_q  <= ctrl2_q[`MFDG_BIT_CRC];
                oversize_q   <= ctrl2_q[`MFDG_BIT_OVERSIZE];
            end
            txAbort_q <= overLimit[0];
            rxAbort_q <= overLimit[1];
        end
    end

    // ****************************************
    // Per-direction byte counters
    // ****************************************
    // Index 0 is transmit, 1 is receive; both are policed alike
    // Counters saturate so a runaway frame never wraps under the limit
    generate
        for (dirIdx = 0; dirIdx < 2; dirIdx = dirIdx + 1) begin : g_police
            reg  [15:0] lenCnt_q;
            always @(posedge ref_clk) begin
                if (!rst_n) begin
                    lenCnt_q <= 16'h0000;
                end else begin
                    lenCnt_q <= lenNext(lenCnt_q, frameIn[dirIdx], byteIn[dirIdx]);
                end
            end
            assign overLimit[dirIdx] = frameIn[dirIdx] & ~oversize_q & (lenCnt_q > maxLen_q);
        end
    endgenerate

    // ****************************************
    // Back-to-back gap timer
    // ****************************************
    // A transmit frame ending while the timer runs restarts it, so the gap
    // is always measured from the latest transmit frame end
    always @* begin
        gapState_d = gapState_q;
        gapCnt_d   = gapCnt_q;
        gapDone_d  = gapDone_q;
        case (gapState_q)
            GAP_IDLE: begin
                if (txEnd) begin
                    gapState_d = GAP_COUNT;
                    gapCnt_d   = gapFull;
                    gapDone_d  = 1'b0;
                end
            end
            GAP_COUNT: begin
                if (txEnd) begin
                    gapCnt_d  = gapFull;
                    gapDone_d = 1'b0;
                end else if (gapCnt_q != 8'h00) begin
                    if (nibbleTick) begin
                        gapCnt_d = gapCnt_q - 8'h01;
                    end
                end else begin
                    gapState_d = GAP_IDLE;
                    gapDone_d  = 1'b1;
                end
            end
            default: begin
                gapState_d = GAP_IDLE;
                gapCnt_d   = 8'h00;
                gapDone_d  = 1'b1;
            end
        endcase
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            gapState_q <= GAP_IDLE;
            gapCnt_q   <= 8'h00;
            gapDone_q  <= 1'b1;
        end else begin
            gapState_q <= gapState_d;
            gapCnt_q   <= gapCnt_d;
            gapDone_q  <= gapDone_d;
        end
    end
endmodule // mfdg_cfg
`default_nettype wire

// ==== bench/mfdg_chk.sv ====
// Port assertions for mfdg_cfg
// Assumes one clock and binding into mfdg_cfg
`timescale 1ns/1ps
`default_nettype none
module mfdg_chk (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        txFrame,
    input wire logic        rxFrame,
    input wire logic        fullDuplex_q,
    input wire logic        crcAppend_q,
    input wire logic        txAbort_q,
    input wire logic        rxAbort_q,
    input wire logic        gapDone_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence sTake; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence sTxIdle; !txFrame [*3]; endsequence
    sequence sRxIdle; !rxFrame [*3]; endsequence
    a_ack_next: assert property (sTake |=> wb_ack_o) else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat idle");
    a_cfg_hold: assert property ($past(txFrame || rxFrame) |-> $stable({fullDuplex_q, crcAppend_q}))
        else $error("cfg moved");
    a_tx_clear: assert property (sTxIdle |-> !txAbort_q) else $error("tx abort");
    a_rx_clear: assert property (sRxIdle |-> !rxAbort_q) else $error("rx abort");
    a_gap_drop: assert property ($fell(txFrame) |=> !gapDone_q) else $error("gap drop");
endmodule // mfdg_chk
bind mfdg_cfg mfdg_chk u_mfdg_chk (.*);
`default_nettype wire

// ==== bench/mfdg_phy.sv ====
// PHY side model: one tx and rx frame per go pulse
// Assumes go lasts one clock
`timescale 1ns/1ps
`default_nettype none
module mfdg_phy (
    input  wire logic       ref_clk,
    input  wire logic       go,
    input  wire logic [7:0] len,
    output logic            txFrame,
    output logic            txByte,
    output logic            rxFrame,
    output logic            rxByte,
    output logic            nibbleTick
);
    logic [8:0] cnt_q = 9'h0;
    logic [1:0] nib_q = 2'h0;
    always @(posedge ref_clk) begin
        nib_q <= nib_q + 2'h1;
        cnt_q <= go ? {len, 1'b0} : cnt_q - {8'h0, cnt_q != 9'h0};
    end
    assign nibbleTick = nib_q == 2'h3;
    assign txFrame = cnt_q != 9'h0;
    assign rxFrame = txFrame;
    assign txByte = txFrame & cnt_q[0];
    assign rxByte = txByte;
endmodule // mfdg_phy
`default_nettype wire

// ==== bench/mfdg_cfg_tb.sv ====
// Self-checking bench for mfdg_cfg
// Assumes mfdg_phy and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "mfdg_consts.vh"
`define CHK(n,e,s) begin testsRun++; if ((s)!==(e)) begin fails++; $display("Error %s exp %h got %h", n, e, s); end end
module mfdg_cfg_tb;
    logic ref_clk = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, go = 0, s, t;
    logic [7:0] wb_adr_i = 0, len = 0;
    logic [3:0] wb_sel_i = 0;
    logic [31:0] wb_dat_i = 0, rd;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, txFrame, txByte, rxFrame, rxByte, nibbleTick, fullDuplex_q, crcAppend_q, txAbort_q, rxAbort_q, gapDone_q;
    int fails = 0, testsRun = 0, ctl, gap, n, i;
    mfdg_cfg u_mfdg_cfg (.*);
    mfdg_phy u_mfdg_phy (.*);
    initial forever #4 ref_clk = ~ref_clk;
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, w, a, d, 4'h3};
        k = 0;
        do begin @(posedge ref_clk); k++; end while (wb_ack_o !== 1'b1 && k < 50);
        if (wb_ack_o !== 1'b1) fails++;
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask
    task complete_run;
        $display("Checks %0d mismatches %0d", testsRun, fails);
        if (fails == 0 && testsRun > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin #100000; fails++; complete_run; end
    initial begin
        void'($urandom(37562));
        repeat (2) @(posedge ref_clk);
        rst_n <= 1;
        bus(0, `MFDG_ADDR_CTRL2, 0); `CHK("ctl rst", 32'h0000_40B2, rd)
        bus(0, `MFDG_ADDR_GAP, 0); `CHK("gap rst", 32'h0000_0012, rd)
        bus(0, 8'h10, 0); `CHK("unmapped", 32'h0, rd)
        bus(1, `MFDG_ADDR_MAXLEN, 32'h0000_0014);
        bus(0, `MFDG_ADDR_MAXLEN, 0); `CHK("maxlen", 32'h0000_0014, rd)
        for (i = 0; i < 4; i++) begin
            gap = $urandom;
            ctl = 32'h0000_40A2 | i[0] | (i[1] << 2) | ($urandom & 16);
            bus(1, `MFDG_ADDR_CTRL2, ctl); bus(1, `MFDG_ADDR_GAP, gap);
            bus(0, `MFDG_ADDR_GAP, 0); `CHK("gap rd", gap & 127, rd)
            bus(0, `MFDG_ADDR_CTRL2, 0); `CHK("ctl rd", ctl, rd)
            `CHK("duplex", ctl[0], fullDuplex_q)
            `CHK("crc", ctl[4], crcAppend_q)
            @(posedge ref_clk); go <= 1; len <= 8'h1E;
            @(posedge ref_clk); go <= 0;
            // Mid-frame rewrite must not reach the frame
            bus(1, `MFDG_ADDR_CTRL2, ctl ^ 32'h11);
            @(posedge ref_clk);
            `CHK("duplex hold", ctl[0], fullDuplex_q)
            `CHK("crc hold", ctl[4], crcAppend_q)
            repeat (2) @(posedge ref_clk);
            while (txFrame === 1'b1) begin s = txAbort_q; t = rxAbort_q; @(posedge ref_clk); end
            `CHK("tx abort", !ctl[2], s)
            `CHK("rx abort", !ctl[2], t)
            n = 0;
            do begin @(posedge ref_clk); n += (gapDone_q === 1'b0 && nibbleTick === 1'b1); end
            while (gapDone_q !== 1'b1);
            `CHK("gap len", (gap & 127) + (ctl[0] ? 3 : 6), n)
            bus(0, `MFDG_ADDR_STATUS, 0);
            `CHK("status", 16 + (ctl[4] ? 0 : 2) + (ctl[0] ? 0 : 1), rd)
        end
        complete_run;
    end
endmodule // mfdg_cfg_tb
`default_nettype wire
